// [usbde_pkg.sv]
// shared constants and types of the usb descriptor engine
package usbde_pkg;
    // endpoint status word layout
    localparam int EP_ENABLE_BIT = 0;
    localparam int EP_STALL_BIT = 1;
    localparam int EP_NAK_BIT = 2;
    localparam int EP_TOGGLE_BIT = 3;
    localparam int EP_HEAD_LSB = 4;
    localparam int EP_HEAD_MSB = 15;
    localparam int EP_MPS_LSB = 22;
    localparam int EP_MPS_MSB = 31;
    // descriptor layout
    localparam int DESC_ALIGN_SHIFT = 4;
    localparam int DESC_W0 = 0;
    localparam int DESC_W1 = 1;
    localparam int DESC_W2 = 2;
    localparam int DESC_DATA_OFS = 12;
    localparam int D_OFS_LSB = 0;
    localparam int D_OFS_MSB = 15;
    localparam int D_CODE_LSB = 16;
    localparam int D_CODE_MSB = 19;
    localparam int D_NEXT_LSB = 4;
    localparam int D_NEXT_MSB = 15;
    localparam int D_LEN_LSB = 16;
    localparam int D_LEN_MSB = 31;
    localparam int D_DIR_BIT = 16;
    localparam int D_IRQ_BIT = 17;
    localparam int D_FULL_BIT = 18;
    localparam int D_FORCE_BIT = 19;
    localparam logic [3:0] CODE_BUSY = 4'hf;
    localparam logic [3:0] CODE_OK = 4'h0;
    // register map
    localparam logic [15:0] STATUS_ADDR = 16'hff00;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_EP_LSB = 4;
    // transaction answers
    typedef enum logic [1:0] {
        HS_IGNORE = 2'h0,
        HS_ACK = 2'h1,
        HS_NAK = 2'h2,
        HS_STALL = 2'h3
    } usbde_hs_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CHECK = 6'h02,
        ST_OUT = 6'h04,
        ST_IN = 6'h08,
        ST_DRAIN = 6'h10,
        ST_FIN = 6'h20
    } usbde_state_t;
endpackage

// [usbde_strm_if.sv]
// valid/ready byte stream between engine and buffer
`timescale 1ns/10ps
interface usbde_strm_if #(parameter int W = 10);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [usbde_buf.sv]
// two-entry skid buffer on the in-direction data path
`timescale 1ns/10ps
module usbde_buf
    import usbde_pkg::*;
#(
    parameter int W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    usbde_strm_if.snk in_s,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic skid_v_q;
    logic [W-1:0] skid_q;
    wire push = in_s.valid && !skid_v_q;
    wire stalled = out_valid && !out_ready;

    assign in_s.ready = !skid_v_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_v_q <= 1'b0;
            skid_q <= '0;
        end else if (stalled) begin
            if (push) begin
                skid_q <= in_s.data;
                skid_v_q <= 1'b1;
            end
        end else if (skid_v_q) begin
            out_data <= skid_q;
            out_valid <= 1'b1;
            skid_v_q <= 1'b0;
        end else begin
            out_valid <= push;
            out_data <= in_s.data;
        end
    end
endmodule // usbde_buf

// [usbde_engine.sv]
// descriptor engine: apb ram slave and per-endpoint descriptor walker
//
// Functional notes
// - descriptors sit on 16-byte aligned addresses
// - word0 low half tracks bytes moved
// - word0 code 0xf busy, 0x0 success
// - word1 next pointer, zero ends list
// - never move more than allocated length
// - word2 bit16 selects out or in
// - word2 bit17 raises interrupt on completion
// - short packet completes the descriptor
// - optional completion when progress equals length
// - force toggle to data1 at completion
// - direction mismatch ignores the whole transaction
// - enabled endpoint with empty list naks
// - endpoint word holds list head pointer
// - endpoint toggle bit flips on success
// - completion pulses that endpoint's event bit; the code pulses it only when word2 bit17 is set
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module usbde_engine
    import usbde_pkg::*;
#(
    parameter int RAM_WORDS = 256,
    parameter int EP_COUNT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tok_valid,
    input wire logic [3:0] tok_ep,
    input wire logic tok_dir_in,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_empty,
    input wire logic tx_ready,
    output logic tx_data1,
    output logic hs_valid,
    output logic [1:0] hs_code,
    output logic [EP_COUNT-1:0] ep_event
);
    localparam int WIDX = $clog2(RAM_WORDS);

    function automatic logic [WIDX-1:0] widx(input logic [15:0] a);
        return a[WIDX+1:2];
    endfunction

    function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] l);
        return w[{l, 3'b000} +: 8];
    endfunction

    // endpoint word i sits at ram word i
    function automatic logic [WIDX-1:0] ep_widx(input logic [3:0] e);
        return WIDX'(e);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [31:0] mem_q [RAM_WORDS];
    usbde_state_t state_q, state_d;
    logic [3:0] ep_q;
    logic dir_in_q;
    logic [15:0] off_q;
    logic [10:0] pkt_q;
    logic [1:0] pend_hs_q;
    logic apb_go_q;

    ////////////////////////////////////////////////////////////////////////////////
    // decode of endpoint and current descriptor
    wire [31:0] ep_w = mem_q[ep_widx(ep_q)];
    wire [11:0] head = ep_w[EP_HEAD_MSB:EP_HEAD_LSB];
    wire [10:0] mps = {1'b0, ep_w[EP_MPS_MSB:EP_MPS_LSB]};
    wire [15:0] dbase = 16'(head) << DESC_ALIGN_SHIFT;
    wire [31:0] d0 = mem_q[widx(dbase + 16'(DESC_W0 * 4))];
    wire [31:0] d1 = mem_q[widx(dbase + 16'(DESC_W1 * 4))];
    wire [31:0] d2 = mem_q[widx(dbase + 16'(DESC_W2 * 4))];
    wire [15:0] dlen = d1[D_LEN_MSB:D_LEN_LSB];
    wire [11:0] dnext = d1[D_NEXT_MSB:D_NEXT_LSB];
    wire ddir_in = d2[D_DIR_BIT];
    wire [15:0] byte_addr = dbase + 16'(DESC_DATA_OFS) + off_q;
    wire [31:0] byte_w = mem_q[widx(byte_addr)];
    wire room = (pkt_q < mps) && (off_q < dlen);
    wire room_next = (pkt_q + 11'h001 < mps) && (off_q + 16'h0001 < dlen);
    wire ep_on = ep_w[EP_ENABLE_BIT];
    wire dir_ok = ddir_in == dir_in_q;
    wire list_empty = head == 12'h000;
    wire ep_blocked = ep_w[EP_STALL_BIT] || ep_w[EP_NAK_BIT];
    wire ep_go = ep_on && !ep_blocked && !list_empty && dir_ok;
    wire ep_ignore = !ep_on || (!ep_blocked && !list_empty && !dir_ok);

    ////////////////////////////////////////////////////////////////////////////////
    // in-direction buffer: {last, no data, byte}
    // a stalled host loses no byte; the buffer holds two
    usbde_strm_if #(.W(10)) tx_s ();
    wire tx_push = (state_q == ST_IN) && tx_s.ready;
    assign tx_s.valid = state_q == ST_IN;
    assign tx_s.data = {!room || !room_next, !room, lane(byte_w, byte_addr[1:0])};
    logic [9:0] tx_word;

    usbde_buf #(.W(10)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_s(tx_s),
        .out_valid(tx_valid),
        .out_data(tx_word),
        .out_ready(tx_ready)
    );
    assign tx_data = tx_word[7:0];
    assign tx_empty = tx_word[8];
    assign tx_last = tx_word[9];

    ////////////////////////////////////////////////////////////////////////////////
    // completion decode
    wire short_pkt = pkt_q < mps;
    wire full_done = d2[D_FULL_BIT] && (off_q == dlen);
    wire complete = short_pkt || full_done;
    wire rx_take = (state_q == ST_OUT) && rx_valid && rx_ready;
    wire rx_store = rx_take && (off_q < dlen);
    wire drain_take = (state_q == ST_DRAIN) && rx_valid && rx_ready;
    wire fin_ack = (state_q == ST_FIN) && (pend_hs_q == HS_ACK);
    wire fire_irq = fin_ack && complete && d2[D_IRQ_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire apb_acc = psel && penable;
    wire apb_done = apb_acc && pready;
    // the bus waits while a transaction runs or a token arrives
    wire apb_take = apb_acc && !pready && (state_q == ST_IDLE) && !tok_valid;
    wire in_ram = paddr < 16'(RAM_WORDS * 4);
    wire is_stat = paddr == STATUS_ADDR;
    wire stat_busy = state_q != ST_IDLE;
    wire [31:0] stat_w = (32'(stat_busy) << STAT_BUSY_BIT) | (32'(ep_q) << STAT_EP_LSB);
    wire [31:0] rd_w = in_ram ? mem_q[widx(paddr)] : (is_stat ? stat_w : 32'h00000000);
    wire apb_err = apb_take && !in_ram && !is_stat;
    wire [31:0] apb_rd = (apb_take && !pwrite) ? rd_w : 32'h00000000;
    // a token in the cycle that answers the bus is dropped
    wire tok_take = (state_q == ST_IDLE) && tok_valid && !apb_go_q;

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                // tokens that arrive while busy are dropped
                if (tok_take) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (ep_go) begin
                    state_d = dir_in_q ? ST_IN : ST_OUT;
                end else if (dir_in_q) begin
                    state_d = ST_FIN;
                end else begin
                    state_d = ST_DRAIN;
                end
            end
            ST_OUT: begin
                if (rx_take && rx_last) begin
                    state_d = ST_FIN;
                end
            end
            ST_DRAIN: begin
                if (drain_take && rx_last) begin
                    state_d = ST_FIN;
                end
            end
            ST_IN: begin
                if (tx_push && (!room || !room_next)) begin
                    state_d = ST_FIN;
                end
            end
            ST_FIN: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ep_q <= 4'h0;
            dir_in_q <= 1'b0;
            off_q <= 16'h0000;
            pkt_q <= 11'h000;
            pend_hs_q <= HS_IGNORE;
            rx_ready <= 1'b0;
            tx_data1 <= 1'b0;
        end else begin
            state_q <= state_d;
            rx_ready <= (state_d == ST_OUT) || (state_d == ST_DRAIN);
            if (tok_take) begin
                ep_q <= tok_ep;
                dir_in_q <= tok_dir_in;
            end
            // the answer code is fixed when the endpoint word is read
            if (state_q == ST_CHECK) begin
                off_q <= d0[D_OFS_MSB:D_OFS_LSB];
                pkt_q <= 11'h000;
                tx_data1 <= ep_w[EP_TOGGLE_BIT];
                if (ep_ignore) begin
                    pend_hs_q <= HS_IGNORE;
                end else if (ep_w[EP_STALL_BIT]) begin
                    pend_hs_q <= HS_STALL;
                end else if (ep_w[EP_NAK_BIT] || list_empty) begin
                    pend_hs_q <= HS_NAK;
                end else begin
                    pend_hs_q <= HS_ACK;
                end
            end
            if (rx_take || tx_push) begin
                pkt_q <= pkt_q + 11'h001;
            end
            // progress stops at the length, the packet count does not
            if (rx_store || (tx_push && room)) begin
                off_q <= off_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answers toward the link and the controller
    // hs_valid, hs_code and ep_event are one-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_valid <= 1'b0;
            hs_code <= HS_IGNORE;
            ep_event <= '0;
        end else begin
            hs_valid <= state_q == ST_FIN;
            hs_code <= (state_q == ST_FIN) ? pend_hs_q : HS_IGNORE;
            ep_event <= '0;
            if (fire_irq) begin
                ep_event[ep_q] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, held waiting while a transaction runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            apb_go_q <= 1'b0;
        end else begin
            apb_go_q <= apb_take;
            pready <= apb_take;
            pslverr <= apb_err;
            prdata <= apb_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ram writes: apb, received bytes, write-back at the end of each acked transaction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < RAM_WORDS; i++) begin
                mem_q[i] <= 32'h00000000;
            end
        end else begin
            if (apb_done && pwrite && in_ram) begin
                mem_q[widx(paddr)] <= pwdata;
            end
            if (rx_store) begin
                mem_q[widx(byte_addr)][{byte_addr[1:0], 3'b000} +: 8] <= rx_data;
            end
            // write-back of progress, toggle and list head
            if (fin_ack) begin
                mem_q[widx(dbase)][D_OFS_MSB:D_OFS_LSB] <= off_q;
                mem_q[ep_widx(ep_q)][EP_TOGGLE_BIT] <= !ep_w[EP_TOGGLE_BIT];
                if (complete) begin
                    mem_q[widx(dbase)][D_CODE_MSB:D_CODE_LSB] <= CODE_OK;
                    mem_q[ep_widx(ep_q)][EP_HEAD_MSB:EP_HEAD_LSB] <= dnext;
                    if (d2[D_FORCE_BIT]) begin
                        mem_q[ep_widx(ep_q)][EP_TOGGLE_BIT] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // usbde_engine

// [usbde_engine_assertions.sv]
// port checker for the descriptor engine
`timescale 1ns/10ps
module usbde_engine_chk #(
    parameter int EP_COUNT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tok_valid,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic hs_valid,
    input wire logic [EP_COUNT-1:0] ep_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    rx_open_a: assert property ($rose(rx_ready) |-> $past(tok_valid, 2))
        else $error("rx_ready early or late");
    rx_close_a: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready ##1 hs_valid)
        else $error("no answer after last byte");
    event_one_a: assert property (ep_event != '0 |-> $onehot(ep_event) && hs_valid)
        else $error("event not one-hot");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("in byte lost in stall");
endmodule // usbde_engine_chk

bind usbde_engine usbde_engine_chk #(.EP_COUNT(EP_COUNT)) chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tok_valid(tok_valid), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .hs_valid(hs_valid), .ep_event(ep_event));

// [usbde_host_model.sv]
// full-speed host model: tokens, out bytes, in sink
`timescale 1ns/10ps
module usbde_host_model (
    input wire logic pclk,
    output logic tok_valid,
    output logic [3:0] tok_ep,
    output logic tok_dir_in,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_empty,
    output logic tx_ready,
    input wire logic hs_valid,
    input wire logic [1:0] hs_code
);
    logic [1:0] hs_q = 2'h0;
    int hs_n = 0;
    logic [7:0] got[$];
    initial begin
        tok_valid = 1'b0;
        tok_ep = 4'h0;
        tok_dir_in = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    always @(posedge pclk) begin
        if (hs_valid) begin
            hs_q <= hs_code;
            hs_n <= hs_n + 1;
        end
    end
    task automatic token(input logic [3:0] ep, input logic din);
        @(posedge pclk);
        tok_valid <= 1'b1;
        tok_ep <= ep;
        tok_dir_in <= din;
        @(posedge pclk);
        tok_valid <= 1'b0;
    endtask
    task automatic send_out(input logic [3:0] ep, input int n, input logic [7:0] b);
        int n0;
        n0 = hs_n;
        token(ep, 1'b0);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= b + 8'(i);
            rx_last <= (i == n - 1);
            do @(posedge pclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        while (hs_n == n0) @(posedge pclk);
    endtask
    task automatic recv_in(input logic [3:0] ep, input logic slow);
        int n0;
        logic done;
        n0 = hs_n;
        done = 1'b0;
        got.delete();
        token(ep, 1'b1);
        while (!done) begin
            @(posedge pclk);
            if (tx_valid && tx_ready) begin
                if (!tx_empty) got.push_back(tx_data);
                done = tx_last;
            end
            tx_ready <= done ? 1'b0 : (slow ? !tx_ready : 1'b1);
        end
        while (hs_n == n0) @(posedge pclk);
    endtask
endmodule // usbde_host_model

// [usbde_engine_bench.sv]
// bench for the usb descriptor engine
`timescale 1ns/10ps
module usbde_engine_bench;
    import usbde_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic tok_valid, tok_dir_in, rx_valid, rx_last, rx_ready;
    logic tx_valid, tx_last, tx_empty, tx_ready, tx_data1, hs_valid;
    logic [3:0] tok_ep;
    logic [7:0] rx_data, tx_data;
    logic [1:0] hs_code;
    logic [15:0] ep_event, ev_q = 16'h0;
    int mismatches = 0, checks = 0, cycles = 0;
    usbde_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_dir_in(tok_dir_in),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_empty(tx_empty),
        .tx_ready(tx_ready), .tx_data1(tx_data1), .hs_valid(hs_valid), .hs_code(hs_code),
        .ep_event(ep_event));
    usbde_host_model host (.pclk(pclk), .tok_valid(tok_valid), .tok_ep(tok_ep),
        .tok_dir_in(tok_dir_in), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_empty(tx_empty), .tx_ready(tx_ready), .hs_valid(hs_valid), .hs_code(hs_code));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (presetn) begin
            ev_q <= ev_q | ep_event;
        end
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask
    task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] ex);
        logic e;
        apb(1'b0, a, 32'h0, e);
        chk(nm, ex, q);
    endtask
    task automatic t_unmapped();
        logic e;
        apb(1'b0, 16'h8000, 32'h0, e);
        chk("unmapped err", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, q);
    endtask
    task automatic t_codes();
        logic [31:0] ew[4] = '{32'h1, 32'h3, 32'h5, 32'h0};
        usbde_hs_t hx[4] = '{HS_NAK, HS_STALL, HS_NAK, HS_IGNORE};
        for (int i = 0; i < 4; i++) begin
            wr(16'h0008, ew[i]);
            host.send_out(4'h2, 1, 8'h55);
            chk("idle answer", 32'(hx[i]), 32'(host.hs_q));
        end
    endtask
    task automatic t_out();
        wr(16'h0080, 32'h000f0000);
        wr(16'h0084, 32'h000800c0);
        wr(16'h0088, 32'h00020000);
        wr(16'h0004, 32'h02000081);
        host.send_out(4'h1, 3, 8'h10);
        chk("out answer", 32'(HS_ACK), 32'(host.hs_q));
        rd("out word0", 16'h0080, 32'h00000003);
        rd("out data", 16'h008c, 32'h00121110);
        rd("out head", 16'h0004, 32'h020000c9);
        chk("out next head", 32'h00c, 32'(q[15:4]));
        chk("out event", 32'h1, 32'(ev_q[1]));
    endtask
    task automatic t_in();
        wr(16'h0100, 32'h000f0000);
        wr(16'h0104, 32'h00080000);
        wr(16'h0108, 32'h000d0000);
        wr(16'h010c, 32'h44332211);
        wr(16'h0110, 32'h88776655);
        wr(16'h0010, 32'h01000101);
        host.send_out(4'h4, 2, 8'ha0);
        chk("wrong dir answer", 32'(HS_IGNORE), 32'(host.hs_q));
        rd("wrong dir word0", 16'h0100, 32'h000f0000);
        for (int p = 0; p < 2; p++) begin
            host.recv_in(4'h4, p[0]);
            chk("in answer", 32'(HS_ACK), 32'(host.hs_q));
            chk("in toggle", 32'(p), 32'(tx_data1));
            chk("in count", 32'h4, 32'(host.got.size()));
            for (int i = 0; i < 4; i++) begin
                chk("in byte", 32'h11 * (4 * p + i + 1), 32'(host.got[i]));
            end
            rd("in word0", 16'h0100, p ? 32'h00000008 : 32'h000f0004);
        end
        rd("in ep word", 16'h0010, 32'h01000009);
        chk("in no event", 32'h0, 32'(ev_q[4]));
        rd("status word", STATUS_ADDR, 32'h00000040);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_unmapped();
        t_codes();
        t_out();
        t_in();
        test_done();
    end
endmodule // usbde_engine_bench
